// ===== design/dacu_dev.sv
`timescale 1ns/1ns
`include "dacu_map.svh"
module dacu_dev (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  dacu_if.dev                            link,
  input  wire logic                      pal_we,
  input  wire dacu_pkg::dacu_byte_t      pal_addr,
  input  wire dacu_pkg::dacu_pal_entry_t pal_wdata,
  output dacu_pkg::dacu_mode_e           color_mode,
  output dacu_pkg::dacu_byte_t           hidden_color_mode_reg,
  output logic                           pix_valid,
  output logic                           direct,
  output dacu_pkg::dacu_byte_t           red,
  output dacu_pkg::dacu_byte_t           green,
  output dacu_pkg::dacu_byte_t           blue
);
  import dacu_pkg::*;

  dacu_dev_s       st_ff;
  dacu_dev_s       nxt_st;
  dacu_pal_entry_t pal_mem [256];
  dacu_mode_e      mode;
  logic            dual;
  logic            rise;
  logic            fall;
  logic            take;
  logic [1:0]      nbytes;
  logic [23:0]     word;
  dacu_byte_t      lut_idx;
  dacu_pal_entry_t lut;

  function automatic dacu_mode_e dacu_decode(input dacu_byte_t code);
    dacu_mode_e m;
    m = DACU_PAL;
    if (!code[`DACU_EXT_BIT]) begin
      m = DACU_PAL;
    end else if ((code & `DACU_IGNORE_B5) == `DACU_CODE_555) begin
      m = DACU_RGB555;
    end else if ((code & `DACU_IGNORE_B5) == `DACU_CODE_565) begin
      m = DACU_RGB565;
    end else if ((code & `DACU_IGNORE_B5) == `DACU_CODE_888) begin
      m = DACU_RGB888;
    end else if ((code & `DACU_IGNORE_B5) == `DACU_CODE_MIX) begin
      m = DACU_MIX;
    end
    return m;
  endfunction : dacu_decode

  assign mode                  = dacu_decode(st_ff.hidden);
  assign color_mode            = mode;
  assign hidden_color_mode_reg = st_ff.hidden;
  assign pix_valid             = st_ff.pix_valid;
  assign direct                = st_ff.direct;
  assign red                   = st_ff.red;
  assign green                 = st_ff.green;
  assign blue                  = st_ff.blue;
  assign link.io_rdata         = st_ff.io_rdata;
  assign link.io_rvalid        = st_ff.io_rvalid;

  // Clocking mode 1 only for 16-bit modes with bit 5 clear; 8-8-8 always rising
  assign dual = (mode != DACU_PAL) && (mode != DACU_RGB888)
                && !st_ff.hidden[`DACU_CLKSEL_BIT];

  always_comb begin
    unique case (mode)
      DACU_PAL:    nbytes = `DACU_BYTES_PAL;
      DACU_RGB888: nbytes = `DACU_BYTES_24;
      DACU_RGB555,
      DACU_RGB565,
      DACU_MIX:    nbytes = `DACU_BYTES_16;
      default:     nbytes = `DACU_BYTES_PAL;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    rise   = 1'b0;
    fall   = 1'b0;
    take   = 1'b0;
    word   = st_ff.acc;

    // Host I/O port
    nxt_st.io_rvalid = 1'b0;
    if (link.io_rd || link.io_wr) begin
      if (link.io_addr != `DACU_PIXMASK_PORT) begin
        nxt_st.rd_cnt = 3'h0;
      end else if (link.io_rd) begin
        if (st_ff.rd_cnt == `DACU_UNLOCK_READS) begin
          nxt_st.io_rdata = st_ff.hidden;
        end else begin
          nxt_st.io_rdata = st_ff.pixmask;
          nxt_st.rd_cnt   = st_ff.rd_cnt + 3'h1;
        end
      end else begin
        if (st_ff.rd_cnt == `DACU_UNLOCK_READS) begin
          nxt_st.hidden = link.io_wdata;
        end else begin
          nxt_st.pixmask = link.io_wdata;
        end
        nxt_st.rd_cnt = 3'h0;
      end
      nxt_st.io_rvalid = link.io_rd;
    end

    // Pin synchronisers; a change counts when stages 2 and 3 agree
    nxt_st.sync_clk   = {st_ff.sync_clk[1:0], link.pix_clk};
    nxt_st.sync_blank = {st_ff.sync_blank[1:0], link.blank_n};
    nxt_st.sync_data  = {st_ff.sync_data[1:0], link.pix_data};
    if (st_ff.sync_clk[1] == st_ff.sync_clk[2]) begin
      nxt_st.clk_f = st_ff.sync_clk[2];
      rise = st_ff.sync_clk[2] && !st_ff.clk_f;
      fall = !st_ff.sync_clk[2] && st_ff.clk_f;
    end
    if (st_ff.sync_blank[1] == st_ff.sync_blank[2]) begin
      nxt_st.blank_f = st_ff.sync_blank[2];
    end

    // Byte capture
    nxt_st.pix_valid = 1'b0;
    if (!nxt_st.blank_f) begin
      nxt_st.idx = 2'h0;
    end else begin
      take = rise || (fall && dual && (st_ff.idx == 2'h1));
    end
    if (take) begin
      unique case (st_ff.idx)
        2'h0:    word[7:0]   = st_ff.sync_data[2];
        2'h1:    word[15:8]  = st_ff.sync_data[2];
        2'h2:    word[23:16] = st_ff.sync_data[2];
        default: word        = st_ff.acc;
      endcase
      nxt_st.acc = word;
      if (st_ff.idx == nbytes - 2'h1) begin
        nxt_st.idx       = 2'h0;
        nxt_st.pix_valid = 1'b1;
      end else begin
        nxt_st.idx = st_ff.idx + 2'h1;
      end
    end

    // Colour formation
    lut_idx = word[7:0] & st_ff.pixmask;
    lut     = pal_mem[lut_idx];
    if (nxt_st.pix_valid) begin
      nxt_st.direct = 1'b1;
      unique case (mode)
        DACU_RGB555: begin
          nxt_st.red   = {word[14:10], 3'h0};
          nxt_st.green = {word[9:5], 3'h0};
          nxt_st.blue  = {word[4:0], 3'h0};
        end
        DACU_RGB565: begin
          nxt_st.red   = {word[15:11], 3'h0};
          nxt_st.green = {word[10:5], 2'h0};
          nxt_st.blue  = {word[4:0], 3'h0};
        end
        DACU_RGB888: begin
          nxt_st.red   = word[23:16];
          nxt_st.green = word[15:8];
          nxt_st.blue  = word[7:0];
        end
        DACU_MIX: begin
          if (word[`DACU_MIX_SEL_BIT]) begin
            nxt_st.direct = 1'b0;
            nxt_st.red    = {lut[17:12], 2'h0};
            nxt_st.green  = {lut[11:6], 2'h0};
            nxt_st.blue   = {lut[5:0], 2'h0};
          end else begin
            nxt_st.red   = {word[14:10], 3'h0};
            nxt_st.green = {word[9:5], 3'h0};
            nxt_st.blue  = {word[4:0], 3'h0};
          end
        end
        default: begin
          nxt_st.direct = 1'b0;
          nxt_st.red    = {lut[17:12], 2'h0};
          nxt_st.green  = {lut[11:6], 2'h0};
          nxt_st.blue   = {lut[5:0], 2'h0};
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff         <= '0;
      st_ff.hidden  <= `DACU_HIDDEN_RST;
      st_ff.pixmask <= `DACU_PIXMASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Palette table, 6 bits per component
  always_ff @(posedge hclk) begin
    if (pal_we) begin
      pal_mem[pal_addr] <= pal_wdata;
    end
  end

endmodule : dacu_dev

// ===== design/dacu_map.svh
`ifndef DACU_MAP_SVH
`define DACU_MAP_SVH

// Device I/O port and hidden register
`define DACU_PIXMASK_PORT   16'h03C6
`define DACU_HIDDEN_RST     8'h00
`define DACU_PIXMASK_RST    8'hFF
`define DACU_UNLOCK_READS   3'h4
`define DACU_EXT_BIT        7
`define DACU_CLKSEL_BIT     5
`define DACU_IGNORE_B5      8'hDF
`define DACU_CODE_555       8'hC0
`define DACU_CODE_565       8'hC1
`define DACU_CODE_888       8'hC5
`define DACU_CODE_MIX       8'hD0

// Pixel word layout
`define DACU_MIX_SEL_BIT    15
`define DACU_BYTES_PAL      2'h1
`define DACU_BYTES_16       2'h2
`define DACU_BYTES_24       2'h3

// Controller registers, word index haddr[3:2]
`define DACU_REG_IO_CMD     2'h0
`define DACU_REG_IO_STAT    2'h1
`define DACU_REG_PIX_CTRL   2'h2
`define DACU_REG_PIX_DATA   2'h3
`define DACU_CMD_WRITE_BIT  24
`define DACU_HALF_CYCLES    3'h4

`endif

// ===== design/dacu_pkg.sv
package dacu_pkg;

  typedef enum logic [4:0] {
    DACU_PAL    = 5'b00001,
    DACU_RGB555 = 5'b00010,
    DACU_RGB565 = 5'b00100,
    DACU_RGB888 = 5'b01000,
    DACU_MIX    = 5'b10000
  } dacu_mode_e;

  typedef logic [7:0]  dacu_byte_t;
  typedef logic [17:0] dacu_pal_entry_t;

  typedef struct packed {
    dacu_byte_t       hidden;
    dacu_byte_t       pixmask;
    logic [2:0]       rd_cnt;
    dacu_byte_t       io_rdata;
    logic             io_rvalid;
    logic [2:0]       sync_clk;
    logic [2:0]       sync_blank;
    logic [2:0][7:0]  sync_data;
    logic             clk_f;
    logic             blank_f;
    logic [1:0]       idx;
    logic [23:0]      acc;
    logic             pix_valid;
    logic             direct;
    dacu_byte_t       red;
    dacu_byte_t       green;
    dacu_byte_t       blue;
  } dacu_dev_s;

  typedef struct packed {
    logic [15:0] io_addr;
    dacu_byte_t  io_wdata;
    logic        io_rd;
    logic        io_wr;
    logic        io_pending;
    dacu_byte_t  io_rdata;
    logic        io_done;
    logic        blank_n;
    logic        dual;
    logic        pix_clk;
    dacu_byte_t  pix_data;
    logic        busy;
    logic [2:0]  half_cnt;
    logic [1:0]  toggles;
    logic        ph_valid;
    logic        ph_write;
    logic [1:0]  ph_idx;
    logic        ph_map;
    logic [31:0] hrdata;
  } dacu_host_s;

endpackage : dacu_pkg

// ===== design/dacu_if.sv
`timescale 1ns/1ns
interface dacu_if;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic        io_rd;
  logic        io_wr;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        blank_n;
  logic        pix_clk;
  logic [7:0]  pix_data;

  modport dev (
    input  io_addr,
    input  io_wdata,
    input  io_rd,
    input  io_wr,
    output io_rdata,
    output io_rvalid,
    input  blank_n,
    input  pix_clk,
    input  pix_data
  );

  modport host (
    output io_addr,
    output io_wdata,
    output io_rd,
    output io_wr,
    input  io_rdata,
    input  io_rvalid,
    output blank_n,
    output pix_clk,
    output pix_data
  );
endinterface : dacu_if

// ===== design/dacu_host.sv
`timescale 1ns/1ns
`include "dacu_map.svh"
module dacu_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  dacu_if.host             link,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  import dacu_pkg::*;

  dacu_host_s st_ff;
  dacu_host_s nxt_st;
  logic       stall;

  assign link.io_addr  = st_ff.io_addr;
  assign link.io_wdata = st_ff.io_wdata;
  assign link.io_rd    = st_ff.io_rd;
  assign link.io_wr    = st_ff.io_wr;
  assign link.blank_n  = st_ff.blank_n;
  assign link.pix_clk  = st_ff.pix_clk;
  assign link.pix_data = st_ff.pix_data;
  assign hresp         = 1'b0;
  assign hrdata        = st_ff.hrdata;

  // Pixel byte writes wait while the previous byte is still on the link
  // Blanking changes also wait, so blank_n never moves mid-byte or mid-park
  assign stall     = st_ff.ph_valid && st_ff.ph_write && st_ff.ph_map
                     && ((st_ff.ph_idx == `DACU_REG_PIX_DATA) || (st_ff.ph_idx == `DACU_REG_PIX_CTRL))
                     && st_ff.busy;
  assign hreadyout = !stall;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.io_rd = 1'b0;
    nxt_st.io_wr = 1'b0;

    if (st_ff.io_pending && link.io_rvalid) begin
      nxt_st.io_rdata   = link.io_rdata;
      nxt_st.io_done    = 1'b1;
      nxt_st.io_pending = 1'b0;
    end

    // Each byte: data first, clock edge half a period later
    if (st_ff.busy) begin
      if (st_ff.half_cnt == 3'h1) begin
        nxt_st.pix_clk  = !st_ff.pix_clk;
        nxt_st.half_cnt = `DACU_HALF_CYCLES;
        nxt_st.toggles  = st_ff.toggles - 2'h1;
        nxt_st.busy     = (st_ff.toggles != 2'h1);
      end else begin
        nxt_st.half_cnt = st_ff.half_cnt - 3'h1;
      end
    end

    // Park the clock low while blanked so each line opens on a rising edge
    if (!st_ff.busy && !st_ff.blank_n && st_ff.pix_clk) begin
      nxt_st.busy     = 1'b1;
      nxt_st.half_cnt = `DACU_HALF_CYCLES;
      nxt_st.toggles  = 2'h1;
    end

    if (st_ff.ph_valid && st_ff.ph_write && st_ff.ph_map && !stall) begin
      unique case (st_ff.ph_idx)
        `DACU_REG_IO_CMD: begin
          nxt_st.io_addr    = hwdata[15:0];
          nxt_st.io_wdata   = hwdata[23:16];
          nxt_st.io_wr      = hwdata[`DACU_CMD_WRITE_BIT];
          nxt_st.io_rd      = !hwdata[`DACU_CMD_WRITE_BIT];
          nxt_st.io_pending = !hwdata[`DACU_CMD_WRITE_BIT];
          nxt_st.io_done    = hwdata[`DACU_CMD_WRITE_BIT];
        end
        `DACU_REG_PIX_CTRL: begin
          nxt_st.blank_n = hwdata[0];
          nxt_st.dual    = hwdata[1];
        end
        `DACU_REG_PIX_DATA: begin
          nxt_st.pix_data = hwdata[7:0];
          nxt_st.busy     = 1'b1;
          nxt_st.half_cnt = `DACU_HALF_CYCLES;
          // Single-edge mode always ends on a rising edge
          nxt_st.toggles  = (st_ff.dual || !st_ff.pix_clk) ? 2'h1 : 2'h2;
        end
        default: begin
        end
      endcase
    end

    if (hready) begin
      nxt_st.ph_valid = hsel && htrans[1];
      nxt_st.ph_write = hwrite;
      nxt_st.ph_idx   = haddr[3:2];
      nxt_st.ph_map   = (haddr[31:4] == 28'h0);
      nxt_st.hrdata   = 32'h0;
      if (hsel && htrans[1] && !hwrite && (haddr[31:4] == 28'h0)) begin
        unique case (haddr[3:2])
          `DACU_REG_IO_CMD:   nxt_st.hrdata = {8'h00, nxt_st.io_wdata, nxt_st.io_addr};
          `DACU_REG_IO_STAT:  nxt_st.hrdata = {22'h0, nxt_st.busy, nxt_st.io_done, nxt_st.io_rdata};
          `DACU_REG_PIX_CTRL: nxt_st.hrdata = {30'h0, nxt_st.dual, nxt_st.blank_n};
          `DACU_REG_PIX_DATA: nxt_st.hrdata = {24'h0, nxt_st.pix_data};
          default:            nxt_st.hrdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : dacu_host

// ===== testbench/dacu_monitor.sv
`timescale 1ns/1ns
`include "dacu_map.svh"
module dacu_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        blank_n,
  input wire logic        pix_clk,
  input wire logic [7:0]  pix_data
);
  logic [2:0] cnt_ff;
  logic [7:0] hid_ff;
  logic [7:0] msk_ff;
  logic       on_port;
  logic       unlocked;
  assign on_port  = io_addr == `DACU_PIXMASK_PORT;
  assign unlocked = cnt_ff == `DACU_UNLOCK_READS;
  // Shadow of the unlock count and both registers behind the port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 3'h0;
      hid_ff <= `DACU_HIDDEN_RST;
      msk_ff <= `DACU_PIXMASK_RST;
    end else if (io_wr) begin
      cnt_ff <= 3'h0;
      if (on_port && unlocked) hid_ff <= io_wdata;
      if (on_port && !unlocked) msk_ff <= io_wdata;
    end else if (io_rd) begin
      cnt_ff <= on_port ? (unlocked ? cnt_ff : cnt_ff + 3'h1) : 3'h0;
    end
  end
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_RD_ANSWER: assert property (io_rd |=> io_rvalid)
    else $error("read not answered next cycle");
  AST_NO_STRAY_ANSWER: assert property (!io_rd |=> !io_rvalid)
    else $error("answer without read");
  AST_HIDDEN_READ: assert property (io_rd && on_port && unlocked |=> io_rdata == hid_ff)
    else $error("unlocked read not hidden value");
  AST_MASK_READ: assert property (io_rd && on_port && !unlocked |=> io_rdata == msk_ff)
    else $error("locked read not mask value");
  AST_RD_WR_APART: assert property (!(io_rd && io_wr))
    else $error("read and write together");
  AST_PIX_HOLD: assert property ($changed(pix_clk) |-> $stable(pix_data))
    else $error("pixel byte moved at clock edge");
  AST_CLK_HALF: assert property ($changed(pix_clk) |=> $stable(pix_clk) [*3])
    else $error("pixel clock half period short");
  AST_BLANK_APART: assert property ($changed(blank_n) |-> $stable(pix_clk))
    else $error("blank edge on clock edge");
endmodule : dacu_monitor

// ===== testbench/truecolor_dac_mode_unpacker_bench.sv
`timescale 1ns/1ns
`include "dacu_map.svh"
module truecolor_dac_mode_unpacker_bench;
  import dacu_pkg::*;
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; $display("[FAIL] %s %h %h", nm, ex, got); end end
  logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp, pal_we, pix_valid, direct;
  logic [31:0]     haddr, hwdata, hrdata;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  dacu_byte_t      pal_addr, hid, red, green, blue, cur_hid;
  dacu_pal_entry_t pal_wdata;
  dacu_mode_e      color_mode;
  int              fails, n_tests, npix;
  dacu_if link_if ();
  dacu_host dacu_host_i (.hclk(hclk), .hresetn(hresetn), .link(link_if), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  dacu_dev dacu_dev_i (.hclk(hclk), .hresetn(hresetn), .link(link_if), .pal_we(pal_we), .pal_addr(pal_addr),
    .pal_wdata(pal_wdata), .color_mode(color_mode), .hidden_color_mode_reg(hid), .pix_valid(pix_valid),
    .direct(direct), .red(red), .green(green), .blue(blue));
  dacu_monitor dacu_monitor_i (.hclk(hclk), .hresetn(hresetn), .io_addr(link_if.io_addr),
    .io_wdata(link_if.io_wdata), .io_rd(link_if.io_rd), .io_wr(link_if.io_wr), .io_rdata(link_if.io_rdata),
    .io_rvalid(link_if.io_rvalid), .blank_n(link_if.blank_n), .pix_clk(link_if.pix_clk),
    .pix_data(link_if.pix_data));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) if (pix_valid === 1'b1) npix <= npix + 1;
  task automatic conclude;
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic wait_rdy;
    int i;
    @(posedge hclk);
    for (i = 0; hreadyout !== 1'b1; i++) begin
      if (i > 400) begin fails++; conclude(); end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
    @(posedge hclk);
  endtask : ahb
  task automatic io_get(input logic [15:0] a, output dacu_byte_t b);
    logic [31:0] r;
    int i;
    ahb(1'b1, 32'h0, {16'h0, a}, r);
    r = 32'h0;
    for (i = 0; r[8] !== 1'b1; i++) begin
      if (i > 20) begin fails++; conclude(); end
      ahb(1'b0, 32'h4, 32'h0, r);
    end
    b = r[7:0];
  endtask : io_get
  task automatic io_put(input logic [15:0] a, input dacu_byte_t b);
    logic [31:0] r;
    ahb(1'b1, 32'h0, {7'h0, 1'b1, b, a}, r);
    repeat (4) @(posedge hclk);
  endtask : io_put
  task automatic set_mode(input dacu_byte_t code);
    dacu_byte_t b;
    int k;
    for (k = 0; k < 4; k++) begin
      io_get(`DACU_PIXMASK_PORT, b);
      `CHK("mask", 8'hFF, b)
    end
    io_get(`DACU_PIXMASK_PORT, b);
    `CHK("hidden read", cur_hid, b)
    io_put(`DACU_PIXMASK_PORT, code);
    cur_hid = code;
    `CHK("hidden", code, hid)
  endtask : set_mode
  task automatic t_modes;
    dacu_byte_t code [8] = '{8'hC0, 8'hE0, 8'hC1, 8'hE5, 8'hC5, 8'hD0, 8'h80, 8'h45};
    dacu_mode_e exp [8] = '{DACU_RGB555, DACU_RGB555, DACU_RGB565, DACU_RGB888, DACU_RGB888, DACU_MIX,
      DACU_PAL, DACU_PAL};
    int k;
    for (k = 0; k < 8; k++) begin
      set_mode(code[k]);
      `CHK("mode", exp[k], color_mode)
    end
  endtask : t_modes
  task automatic t_relock;
    dacu_byte_t b;
    int k;
    for (k = 0; k < 4; k++) io_get(`DACU_PIXMASK_PORT, b);
    io_get(16'h03C8, b);
    io_put(`DACU_PIXMASK_PORT, 8'hFF);
    `CHK("relock", cur_hid, hid)
    io_get(`DACU_PIXMASK_PORT, b);
    `CHK("relock read", 8'hFF, b)
    io_get(16'h03C8, b);
  endtask : t_relock
  task automatic t_pix(input dacu_byte_t code, input logic dual, input int n, input logic [23:0] px,
                       input logic [23:0] rgb, input logic dir);
    logic [31:0] r;
    int i, n0;
    set_mode(code);
    ahb(1'b1, 32'h8, {30'h0, dual, 1'b0}, r);
    ahb(1'b1, 32'h8, {30'h0, dual, 1'b1}, r);
    n0 = npix;
    for (i = 0; i < n; i++) ahb(1'b1, 32'hC, {24'h0, px[8*i +: 8]}, r);
    for (i = 0; npix == n0; i++) begin
      if (i > 300) begin fails++; conclude(); end
      @(posedge hclk);
    end
    `CHK("rgb", rgb, {red, green, blue})
    `CHK("direct", dir, direct)
  endtask : t_pix
  initial begin
    logic [31:0] r;
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; pal_we = 1'b0; pal_addr = 8'h00; pal_wdata = 18'h00000; cur_hid = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("reset hidden", 8'h00, hid)
    `CHK("reset mode", DACU_PAL, color_mode)
    pal_we <= 1'b1; pal_addr <= 8'h5A; pal_wdata <= {6'h2A, 6'h15, 6'h3F};
    @(posedge hclk);
    pal_we <= 1'b0;
    ahb(1'b0, 32'h10, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    t_modes();
    t_relock();
    t_pix(8'hC5, 1'b0, 3, 24'hA1B2C3, 24'hA1B2C3, 1'b1);
    t_pix(8'hC0, 1'b1, 2, 24'h0083E0, 24'h00F800, 1'b1);
    t_pix(8'hE0, 1'b0, 2, 24'h007C00, 24'hF80000, 1'b1);
    t_pix(8'hE1, 1'b0, 2, 24'h0007E0, 24'h00FC00, 1'b1);
    t_pix(8'h00, 1'b0, 1, 24'h00005A, 24'hA854FC, 1'b0);
    t_pix(8'hD0, 1'b1, 2, 24'h00FF5A, 24'hA854FC, 1'b0);
    t_pix(8'hD0, 1'b1, 2, 24'h0003E0, 24'h00F800, 1'b1);
    conclude();
  end
endmodule : truecolor_dac_mode_unpacker_bench
